/* design/cmbs_params.svh */
// Register offsets, field positions and reset values of the message buffer store
`ifndef CMBS_PARAMS_SVH
`define CMBS_PARAMS_SVH
// Window select, address bits 5:4
`define CMBS_WIN_TX 2'h0
`define CMBS_WIN_RX 2'h1
`define CMBS_WIN_CTL 2'h2
// Field offsets inside a buffer window, address bits 3:0
`define CMBS_F_ID_HIGH 4'h0
`define CMBS_F_ID_LOW 4'h1
`define CMBS_F_ID_EXT2 4'h2
`define CMBS_F_ID_EXT3 4'h3
`define CMBS_F_DATA0 4'h4
`define CMBS_F_DATA7 4'hB
`define CMBS_F_LENGTH 4'hC
`define CMBS_F_PRIO 4'hD
`define CMBS_F_STAMP_HI 4'hE
`define CMBS_F_STAMP_LO 4'hF
// Offsets inside the control window
`define CMBS_C_CTRL 4'h0
`define CMBS_C_TXFLAG 4'h1
`define CMBS_C_TXSEL 4'h2
// Bit positions
`define CMBS_B_INIT 0
`define CMBS_B_TIME 1
`define CMBS_B_RTR 4
`define CMBS_B_IDE 3
// Length code and byte limit
`define CMBS_MAX_BYTES 4'h8
// Reset values
`define CMBS_CTRL_RESET 2'h1
`define CMBS_TXSEL_RESET 2'h0
`define CMBS_TIMER_RESET 16'h0000
`endif

/* design/cmbs_pkg.sv */
// Types shared by the message buffer store
package cmbs_pkg;
    typedef logic [7:0] cmbs_byte_t;
    typedef logic [15:0] cmbs_stamp_t;
    typedef enum logic [1:0] {
        cmbs_st_idle = 2'b01,
        cmbs_st_busy = 2'b10
    } cmbs_state_t;
endpackage

/* design/cmbs_store.sv */
// CAN message buffer store: transmit buffers, receive buffer, scheduling, time stamp
`timescale 1ns/100ps
`include "cmbs_params.svh"
module cmbs_store #(
    parameter int NUM_TX = 3
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [5:0] reg_addr,
    input wire cmbs_pkg::cmbs_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output cmbs_pkg::cmbs_byte_t reg_rdata,
    input wire logic bit_tick,
    input wire logic sof_req,
    input wire logic tx_acked,
    input wire logic tx_aborted,
    input wire logic rx_acked,
    input wire cmbs_pkg::cmbs_byte_t rx_id_high,
    input wire cmbs_pkg::cmbs_byte_t rx_id_low_flags,
    input wire cmbs_pkg::cmbs_byte_t rx_length,
    input wire logic [63:0] rx_payload,
    output logic tx_start,
    output logic [1:0] tx_index,
    output logic [10:0] tx_identifier,
    output logic tx_remote,
    output logic tx_extended,
    output logic [3:0] tx_length_code,
    output logic [3:0] tx_byte_count,
    output logic [63:0] tx_payload,
    output logic [NUM_TX-1:0] tx_empty_flags,
    output logic init_mode
);
    import cmbs_pkg::*;

    localparam int BW = $clog2(NUM_TX + 1);
    localparam logic [BW-1:0] RXI = BW'(NUM_TX);

    // Buffer storage; the receive buffer sits after the transmit buffers
    cmbs_byte_t idh [NUM_TX+1];
    cmbs_byte_t idl [NUM_TX+1];
    cmbs_byte_t ex2 [NUM_TX+1];
    cmbs_byte_t ex3 [NUM_TX+1];
    cmbs_byte_t len [NUM_TX+1];
    cmbs_byte_t prio [NUM_TX+1];
    cmbs_byte_t dat [NUM_TX+1][8];
    cmbs_stamp_t stamp [NUM_TX+1];

    cmbs_state_t state_q;
    cmbs_state_t state_d;
    logic [NUM_TX-1:0] txe_q;
    logic [NUM_TX-1:0] txe_d;
    logic [BW-1:0] sel_q;
    logic [BW-1:0] act_q;
    logic [1:0] ctrl_q;
    cmbs_stamp_t timer_q;
    cmbs_byte_t rdata_q;
    logic start_q;

    // Byte count of a frame: remote frames carry none, codes above eight clamp
    function automatic logic [3:0] byte_count(input cmbs_byte_t lc, input logic remote);
        logic [3:0] c;
        c = (lc[3:0] > `CMBS_MAX_BYTES) ? `CMBS_MAX_BYTES : lc[3:0];
        return remote ? 4'h0 : c;
    endfunction

    // One read field of a buffer window, used for both transmit and receive
    function automatic cmbs_byte_t field_read(input logic [3:0] f, input logic [BW-1:0] b,
                                              input logic open, input logic is_tx);
        cmbs_byte_t v;
        v = 8'h00;
        case (f)
            `CMBS_F_ID_HIGH: v = idh[b];
            `CMBS_F_ID_LOW: v = idl[b];
            `CMBS_F_ID_EXT2: v = ex2[b];
            `CMBS_F_ID_EXT3: v = ex3[b];
            `CMBS_F_LENGTH: v = len[b];
            `CMBS_F_PRIO: v = (is_tx && open) ? prio[b] : 8'h00;
            `CMBS_F_STAMP_HI: v = open ? stamp[b][15:8] : 8'h00;
            `CMBS_F_STAMP_LO: v = open ? stamp[b][7:0] : 8'h00;
            default: v = dat[b][3'(f - `CMBS_F_DATA0)];
        endcase
        return v;
    endfunction

    // Lowest priority value wins; strict compare keeps the lowest index on ties
    function automatic logic [BW:0] pick(input logic [NUM_TX-1:0] pend);
        cmbs_byte_t best;
        logic [BW-1:0] bi;
        logic f;
        best = 8'hFF;
        bi = '0;
        f = 1'b0;
        for (int i = 0; i < NUM_TX; i++) begin
            if (pend[i] && (!f || prio[i] < best)) begin
                f = 1'b1;
                best = prio[i];
                bi = BW'(i);
            end
        end
        return {f, bi};
    endfunction

    // Address decode
    wire [1:0] win = reg_addr[5:4];
    wire [3:0] fld = reg_addr[3:0];
    wire is_tx = (win == `CMBS_WIN_TX);
    wire is_rx = (win == `CMBS_WIN_RX);
    wire is_ctl = (win == `CMBS_WIN_CTL);
    wire [BW-1:0] wbuf = is_tx ? sel_q : RXI;
    // Select writes above the last buffer are refused, so sel_q always indexes a flag
    wire sel_empty = txe_q[sel_q];
    // A pending transmit buffer is frozen so the engine never sees a half update
    wire buf_wr = reg_wr && ((is_tx && sel_empty) || is_rx);
    wire is_data = (fld >= `CMBS_F_DATA0) && (fld <= `CMBS_F_DATA7);

    // Read mux
    wire cmbs_byte_t ctl_rd = (fld == `CMBS_C_CTRL) ? {6'h00, ctrl_q} :
                              (fld == `CMBS_C_TXFLAG) ? 8'(txe_q) :
                              (fld == `CMBS_C_TXSEL) ? 8'(sel_q) : 8'h00;
    wire cmbs_byte_t rd_mux = is_tx ? field_read(fld, sel_q, sel_empty, 1'b1) :
                              is_rx ? field_read(fld, RXI, 1'b1, 1'b0) :
                              is_ctl ? ctl_rd : 8'h00;

    // Scheduling only runs outside initialization mode and while idle
    wire [NUM_TX-1:0] pend = ~txe_q;
    wire [BW:0] win_pick = pick(pend);
    wire do_start = (state_q == cmbs_st_idle) && sof_req && !ctrl_q[`CMBS_B_INIT]
                    && win_pick[BW];
    wire [BW-1:0] nb = win_pick[BW-1:0];
    wire busy_ack = (state_q == cmbs_st_busy) && tx_acked;
    wire stamp_en = ctrl_q[`CMBS_B_TIME];
    wire nb_remote = idl[nb][`CMBS_B_RTR];
    wire [3:0] nb_count = byte_count(len[nb], nb_remote);
    wire [3:0] rx_count = byte_count(rx_length, rx_id_low_flags[`CMBS_B_RTR]);

    // Payload sent: bytes past the count go out as zero
    wire [63:0] nb_payload;
    genvar k;
    generate
        for (k = 0; k < 8; k++) begin : g_pay
            assign nb_payload[k*8 +: 8] = (4'(k) < nb_count) ? dat[nb][k] : 8'h00;
        end
    endgenerate

    // Empty flags: a completed transmission sets, a software write of one clears
    always_comb begin
        txe_d = txe_q;
        if (reg_wr && is_ctl && fld == `CMBS_C_TXFLAG) begin
            txe_d = txe_q & ~reg_wdata[NUM_TX-1:0];
        end
        if (busy_ack) begin
            txe_d[act_q] = 1'b1; // Set beats a clear in the same cycle
        end
    end

    // Transmit sequencer: arbitration lost or error returns to idle with the
    // buffer still pending, so it competes again at the next SOF
    always_comb begin
        case (state_q)
            cmbs_st_idle: state_d = do_start ? cmbs_st_busy : cmbs_st_idle;
            cmbs_st_busy: state_d = (tx_acked || tx_aborted) ? cmbs_st_idle : cmbs_st_busy;
            default: state_d = cmbs_st_idle;
        endcase
    end

    // Control state
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= cmbs_st_idle;
            txe_q <= '1;
            sel_q <= `CMBS_TXSEL_RESET;
            ctrl_q <= `CMBS_CTRL_RESET;
            rdata_q <= 8'h00;
            start_q <= 1'b0;
            act_q <= '0;
        end else begin
            state_q <= state_d;
            txe_q <= txe_d;
            start_q <= do_start;
            rdata_q <= reg_rd ? rd_mux : 8'h00;
            if (do_start) begin
                act_q <= nb;
            end
            if (reg_wr && is_ctl && fld == `CMBS_C_CTRL) begin
                ctrl_q <= reg_wdata[1:0];
            end
            if (reg_wr && is_ctl && fld == `CMBS_C_TXSEL && reg_wdata < 8'(NUM_TX)) begin
                sel_q <= BW'(reg_wdata);
            end
        end
    end

    // Stamp timer counts bit times and wraps silently
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            timer_q <= `CMBS_TIMER_RESET;
        end else if (ctrl_q[`CMBS_B_INIT]) begin
            timer_q <= `CMBS_TIMER_RESET;
        end else if (bit_tick) begin
            timer_q <= timer_q + 16'h0001;
        end
    end

    // Frame fields handed to the bit engine, captured at the start decision
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_index <= 2'h0;
            tx_identifier <= 11'h000;
            tx_remote <= 1'b0;
            tx_extended <= 1'b0;
            tx_length_code <= 4'h0;
            tx_byte_count <= 4'h0;
            tx_payload <= 64'h0000_0000_0000_0000;
        end else if (do_start) begin
            tx_index <= 2'(nb);
            // Bit 10 goes out first; smaller values win on the bus
            tx_identifier <= {idh[nb], idl[nb][7:5]};
            tx_remote <= nb_remote;
            tx_extended <= idl[nb][`CMBS_B_IDE];
            tx_length_code <= len[nb][3:0];
            tx_byte_count <= nb_count;
            tx_payload <= nb_payload;
        end
    end

    // Buffer contents: software writes, then receive capture and stamps override
    always_ff @(posedge mclk) begin
        if (buf_wr) begin
            case (fld)
                `CMBS_F_ID_HIGH: idh[wbuf] <= reg_wdata;
                `CMBS_F_ID_LOW: idl[wbuf] <= reg_wdata;
                `CMBS_F_ID_EXT2: ex2[wbuf] <= reg_wdata;
                `CMBS_F_ID_EXT3: ex3[wbuf] <= reg_wdata;
                `CMBS_F_LENGTH: len[wbuf] <= reg_wdata;
                `CMBS_F_PRIO: prio[wbuf] <= reg_wdata;
                default: begin // Stamp fields land here and are dropped
                    if (is_data) begin
                        dat[wbuf][3'(fld - `CMBS_F_DATA0)] <= reg_wdata;
                    end
                end
            endcase
        end
        if (rx_acked) begin
            idh[RXI] <= rx_id_high;
            idl[RXI] <= rx_id_low_flags;
            len[RXI] <= rx_length;
            for (int i = 0; i < 8; i++) begin
                if (4'(i) < rx_count) begin
                    dat[RXI][i] <= rx_payload[i*8 +: 8];
                end
            end
            if (stamp_en) begin
                stamp[RXI] <= timer_q;
            end
        end
        if (busy_ack && stamp_en) begin
            stamp[act_q] <= timer_q;
        end
    end

    // Outputs
    assign reg_rdata = rdata_q;
    assign tx_start = start_q;
    assign tx_empty_flags = txe_q;
    assign init_mode = ctrl_q[`CMBS_B_INIT];

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // Winner really is the smallest priority, lowest index on a tie
    logic win_best;
    always_comb begin
        win_best = 1'b1;
        for (int i = 0; i < NUM_TX; i++) begin
            if (pend[i] && (prio[i] < prio[nb] || (prio[i] == prio[nb] && BW'(i) < nb))) begin
                win_best = 1'b0;
            end
        end
    end

    property p_lowest;
        do_start |-> win_best;
    endproperty
    a_lowest: assert property (p_lowest) else $error("winner not lowest priority");

    property p_id_map;
        start_q |-> tx_identifier == {idh[act_q], idl[act_q][7:5]};
    endproperty
    a_id_map: assert property (p_id_map) else $error("identifier mapping wrong");

    property p_remote;
        start_q && tx_remote |-> tx_byte_count == 4'h0 && tx_payload == 64'h0000_0000_0000_0000;
    endproperty
    a_remote: assert property (p_remote) else $error("remote frame carries data");

    property p_count;
        start_q |-> tx_byte_count <= `CMBS_MAX_BYTES;
    endproperty
    a_count: assert property (p_count) else $error("byte count above eight");

    property p_start_pending;
        start_q |-> $past(sof_req) && !$past(txe_q[nb]);
    endproperty
    a_start_pending: assert property (p_start_pending) else $error("start without pending");

    property p_prio_locked;
        reg_wr && is_tx && fld == `CMBS_F_PRIO && !sel_empty
            |=> prio[$past(sel_q)] == $past(prio[sel_q]);
    endproperty
    a_prio_locked: assert property (p_prio_locked) else $error("priority written while pending");

    property p_timer_init;
        init_mode |=> timer_q == 16'h0000;
    endproperty
    a_timer_init: assert property (p_timer_init) else $error("timer not cleared in init");

    property p_timer_count;
        !init_mode && bit_tick |=> timer_q == $past(timer_q) + 16'h0001;
    endproperty
    a_timer_count: assert property (p_timer_count) else $error("timer did not advance");

    property p_stamp;
        busy_ack && stamp_en |=> stamp[$past(act_q)] == $past(timer_q) && txe_q[$past(act_q)];
    endproperty
    a_stamp: assert property (p_stamp) else $error("ack did not stamp or free buffer");

endmodule

/* bench/cmbs_engine_model.sv */
// Behavioural CAN engine facing the store: bit ticks, frame strobes, receive fields
`timescale 1ns/100ps
module cmbs_engine_model (
    input wire logic mclk,
    output logic bit_tick,
    output logic sof_req,
    output logic tx_acked,
    output logic tx_aborted,
    output logic rx_acked,
    output cmbs_pkg::cmbs_byte_t rx_id_high,
    output cmbs_pkg::cmbs_byte_t rx_id_low_flags,
    output cmbs_pkg::cmbs_byte_t rx_length,
    output logic [63:0] rx_payload
);
    import cmbs_pkg::*;
    // Everything idle at time zero
    initial begin
        {bit_tick, sof_req, tx_acked, tx_aborted, rx_acked} = 5'h00;
        {rx_id_high, rx_id_low_flags, rx_length, rx_payload} = 88'h0;
    end
    // One bit time of the bus clock
    task automatic tick;
        bit_tick <= 1'b1;
        @(posedge mclk);
        bit_tick <= 1'b0;
        @(posedge mclk);
    endtask
    // Bus free: arbitration about to start, the caller watches for the start
    task automatic sof;
        sof_req <= 1'b1;
        @(posedge mclk);
        sof_req <= 1'b0;
    endtask
    // End of the frame in flight, acknowledged or lost
    task automatic ack(input logic lost);
        if (lost) begin
            tx_aborted <= 1'b1;
        end else begin
            tx_acked <= 1'b1;
        end
        @(posedge mclk);
        tx_acked <= 1'b0;
        tx_aborted <= 1'b0;
        @(posedge mclk);
    endtask
    // Received frame; fields are scrambled afterwards so stale values never match
    task automatic rx(input cmbs_byte_t h, input cmbs_byte_t l, input cmbs_byte_t n,
            input logic [63:0] p);
        {rx_id_high, rx_id_low_flags, rx_length, rx_payload} <= {h, l, n, p};
        rx_acked <= 1'b1;
        @(posedge mclk);
        rx_acked <= 1'b0;
        {rx_id_high, rx_id_low_flags, rx_length, rx_payload} <= ~{h, l, n, p};
        @(posedge mclk);
    endtask
endmodule

/* bench/tb_cmbs_store.sv */
// Self-checking testbench for the CAN message buffer store
`timescale 1ns/100ps
module tb_cmbs_store;
    import cmbs_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [5:0] reg_addr = 6'h00;
    cmbs_byte_t reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    cmbs_byte_t reg_rdata, rx_id_high, rx_id_low_flags, rx_length;
    logic bit_tick, sof_req, tx_acked, tx_aborted, rx_acked, tx_start, tx_remote;
    logic tx_extended, init_mode;
    logic [63:0] rx_payload, tx_payload;
    logic [1:0] tx_index;
    logic [10:0] tx_identifier;
    logic [3:0] tx_length_code, tx_byte_count;
    logic [2:0] tx_empty_flags;
    int n_fail = 0;
    int total_checks = 0;

    // 25 MHz clock
    always #20 mclk = ~mclk;

    cmbs_store #(.NUM_TX(3)) dut_u (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bit_tick(bit_tick), .sof_req(sof_req), .tx_acked(tx_acked),
        .tx_aborted(tx_aborted), .rx_acked(rx_acked), .rx_id_high(rx_id_high),
        .rx_id_low_flags(rx_id_low_flags), .rx_length(rx_length), .rx_payload(rx_payload),
        .tx_start(tx_start), .tx_index(tx_index), .tx_identifier(tx_identifier),
        .tx_remote(tx_remote), .tx_extended(tx_extended), .tx_length_code(tx_length_code),
        .tx_byte_count(tx_byte_count), .tx_payload(tx_payload),
        .tx_empty_flags(tx_empty_flags), .init_mode(init_mode));

    cmbs_engine_model eng_u (.mclk(mclk), .bit_tick(bit_tick), .sof_req(sof_req),
        .tx_acked(tx_acked), .tx_aborted(tx_aborted), .rx_acked(rx_acked),
        .rx_id_high(rx_id_high), .rx_id_low_flags(rx_id_low_flags), .rx_length(rx_length),
        .rx_payload(rx_payload));

    task automatic results;
        $display("Checks made %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Register write: one strobe cycle, then one idle cycle
    task automatic wr(input logic [5:0] a, input cmbs_byte_t d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask

    // Register read: data stands only in the cycle after the strobe
    task automatic rd(input logic [5:0] a, input cmbs_byte_t exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk({56'h0, reg_rdata}, {56'h0, exp}, "register read");
        @(posedge mclk);
    endtask

    // Level outputs, sampled clear of the edge
    task automatic levels(input logic [2:0] flags, input logic init);
        #1 chk({61'h0, tx_empty_flags}, {61'h0, flags}, "empty flags");
        chk({63'h0, init_mode}, {63'h0, init}, "init mode");
        @(posedge mclk);
    endtask

    // Fill the selected buffer, then hand it to the engine
    task automatic load(input logic [1:0] idx, input cmbs_byte_t idh, input cmbs_byte_t idl,
            input cmbs_byte_t base, input cmbs_byte_t len, input cmbs_byte_t prio);
        wr(6'h22, {6'h00, idx});
        wr(6'h00, idh);
        wr(6'h01, idl);
        wr(6'h02, 8'hFF);
        wr(6'h03, 8'hFF);
        for (int k = 0; k < 8; k++) begin
            wr(6'h04 + 6'(k), base + 8'(k));
        end
        wr(6'h0C, len);
        wr(6'h0D, prio);
        wr(6'h21, 8'h01 << idx);
    endtask

    // Bus free: expect a start with these fields within a few cycles
    task automatic frame(input logic [1:0] idx, input logic [10:0] id, input logic rem,
            input logic [3:0] code, input logic [3:0] cnt, input logic [63:0] pay);
        bit seen;
        seen = 1'b0;
        eng_u.sof();
        for (int i = 0; i < 4 && !seen; i++) begin
            #1;
            if (tx_start === 1'b1) seen = 1'b1;
            else @(posedge mclk);
        end
        if (!seen) begin
            chk(64'h0, 64'h1, "no transmit start");
            results();
        end
        chk({62'h0, tx_index}, {62'h0, idx}, "buffer chosen");
        chk({53'h0, tx_identifier}, {53'h0, id}, "identifier");
        // Only buffer 1 is loaded with the extended format bit set
        chk({62'h0, tx_remote, tx_extended}, {62'h0, rem, idx == 2'h1}, "remote and format");
        chk({56'h0, tx_length_code, tx_byte_count}, {56'h0, code, cnt}, "length");
        chk(tx_payload, pay, "payload");
        @(posedge mclk);
        #1 chk({63'h0, tx_start}, 64'h0, "start pulse length");
        @(posedge mclk);
    endtask

    // Bus free but nothing may start
    task automatic nostart;
        eng_u.sof();
        repeat (3) begin
            #1 chk({63'h0, tx_start}, 64'h0, "refused start");
            @(posedge mclk);
        end
    endtask

    // Main sequence; expected stamps follow from the ticks driven since initialization ended
    initial begin
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        levels(3'h7, 1'b1);
        rd(6'h20, 8'h01);
        rd(6'h22, 8'h00);
        rd(6'h30, 8'h00);
        repeat (3) eng_u.tick();
        load(2'h0, 8'hA5, 8'h60, 8'h10, 8'h03, 8'h05);
        load(2'h1, 8'h12, 8'h28, 8'h20, 8'h09, 8'h05);
        load(2'h2, 8'h00, 8'hF0, 8'h30, 8'h04, 8'h02);
        levels(3'h0, 1'b1);
        nostart();
        wr(6'h20, 8'h02);
        levels(3'h0, 1'b0);
        // Pending buffer is locked against software
        wr(6'h22, 8'h01);
        wr(6'h00, 8'h00);
        wr(6'h0D, 8'h00);
        rd(6'h0D, 8'h00);
        repeat (5) eng_u.tick();
        frame(2'h2, 11'h007, 1'b1, 4'h4, 4'h0, 64'h0);
        eng_u.ack(1'b0);
        levels(3'h4, 1'b0);
        wr(6'h22, 8'h02);
        rd(6'h0E, 8'h00);
        rd(6'h0F, 8'h05);
        wr(6'h0F, 8'hAA);
        rd(6'h0F, 8'h05);
        rd(6'h0D, 8'h02);
        repeat (2) eng_u.tick();
        frame(2'h0, 11'h52B, 1'b0, 4'h3, 4'h3, 64'h0000_0000_0012_1110);
        eng_u.ack(1'b1);
        frame(2'h0, 11'h52B, 1'b0, 4'h3, 4'h3, 64'h0000_0000_0012_1110);
        eng_u.ack(1'b0);
        frame(2'h1, 11'h091, 1'b0, 4'h9, 4'h8, 64'h2726_2524_2322_2120);
        eng_u.ack(1'b0);
        levels(3'h7, 1'b0);
        nostart();
        // Receive: only length-code bytes move, stamp follows the timer
        wr(6'h16, 8'h77);
        eng_u.tick();
        eng_u.rx(8'h3C, 8'h08, 8'h02, 64'h0000_0000_0000_AABB);
        rd(6'h10, 8'h3C);
        rd(6'h11, 8'h08);
        rd(6'h14, 8'hBB);
        rd(6'h15, 8'hAA);
        rd(6'h16, 8'h77);
        rd(6'h1C, 8'h02);
        rd(6'h1F, 8'h08);
        // Back through initialization: the timer restarts from zero
        wr(6'h20, 8'h03);
        wr(6'h20, 8'h02);
        eng_u.tick();
        // Remote frame: flag captured, no payload byte moves
        eng_u.rx(8'h01, 8'h10, 8'h00, 64'h0);
        rd(6'h11, 8'h10);
        rd(6'h14, 8'hBB);
        rd(6'h1E, 8'h00);
        rd(6'h1F, 8'h01);
        results();
    end
endmodule
